// File: verilog/radio_framer.sv
// Baseband mode selection, packet framing, spreading and checksum control.
// Registers over Avalon-MM; symbols and bits face an external modem.
`default_nettype none

module radio_framer
	import framer_pkg::*;
#(
	parameter int BIT_CYCLES = GFSK_BIT_CYCLES,
	parameter int CHANNELS = CHAN_COUNT
)(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	output logic tx_byte_ready,
	output logic tx_sym_valid,
	input wire logic tx_sym_ready,
	output logic [63:0] tx_chips,
	output logic tx_bit,
	output logic tx_bit_strobe,
	input wire logic rx_sym_valid,
	input wire logic [63:0] rx_chips,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic [6:0] channel,
	output logic irq_o,
	output logic irq_oe,
	input wire logic spi_sdo,
	input wire logic spi_sdo_en,
	output logic miso_o,
	output logic miso_oe
);
	if (BIT_CYCLES < 1 || BIT_CYCLES > 256) $error("BIT_CYCLES out of range");
	if (CHANNELS < 1 || CHANNELS > 128) $error("CHANNELS out of range");

	localparam logic [7:0] BIT_RELOAD = 8'(BIT_CYCLES - 1);
	localparam logic [7:0] CHAN_LIMIT = 8'(CHANNELS);

	typedef struct packed {
		logic [1:0] mode;
		logic code64, mark, len, crc, aack, zseed, rxen;
		logic [15:0] seed;
		logic [7:0] txlen;
		logic [6:0] chan;
		logic [1:0] irqm;
		logic spi3, irqg, misog, irqoe, misooe;
		logic rxdone, crcerr, acksent, txdone;
		logic [7:0] rxlen;
		logic [1:0] a_mode;
		logic a_code64, a_mark, a_len, a_crc;
		logic ack;
		logic [31:0] rdata;
		tx_state_t tst;
		logic go_pend, ack_pend, is_ack, mcnt, have, bit_v, strobe;
		logic [3:0] left;
		logic [7:0] sh, bcnt, timer;
		logic [15:0] crc_t;
		logic [63:0] chips;
		rx_state_t rst;
		logic [1:0] r_mode;
		logic [7:0] acc, rcnt, rbyte;
		logic [3:0] nbits;
		logic [15:0] crc_a, crc_z, rcv, rsh;
		logic rcb, rbyte_v;
	} state_t;

	state_t s, n;
	logic [15:0] crc_t_next, crc_a_next, crc_z_next;
	logic [7:0] tx_fetch, rx_b;

	// Bits per symbol for each mode
	function automatic logic [3:0] wid(input logic [1:0] m);
		case (m)
			MODE_BYTE: wid = 4'h8;
			MODE_DOUBLE: wid = 4'h2;
			default: wid = 4'h1;
		endcase
	endfunction

	// Replicates the low bits of a piece across a symbol byte
	function automatic logic [7:0] spread(input logic [1:0] m, input logic [7:0] p);
		case (m)
			MODE_BYTE: spread = p;
			MODE_DOUBLE: spread = {4{p[1:0]}};
			default: spread = {8{p[0]}};
		endcase
	endfunction

	// Chips carry the symbol byte folded onto the code; short codes clear the top half
	function automatic logic [63:0] chipify(input logic [63:0] code, input logic c64,
		input logic [7:0] sym);
		logic [63:0] v;
		v = code ^ {8{sym}};
		chipify = c64 ? v : {32'h0000_0000, v[31:0]};
	endfunction

	crc16_byte tx_crc (.crc_in(s.crc_t), .data(tx_fetch), .crc_out(crc_t_next));
	crc16_byte rx_crc_seed (.crc_in(s.crc_a), .data(rx_b), .crc_out(crc_a_next));
	crc16_byte rx_crc_zero (.crc_in(s.crc_z), .data(rx_b), .crc_out(crc_z_next));

	// The whole next state in one pass; bus clears come first so hardware sets win
	always_comb begin
		logic gf, adv, emit, fetch, got, last, corr, pval, done, ok, bad;
		logic [7:0] b, sym, piece, tag;
		logic [3:0] w;
		logic [63:0] mk;
		n = s;
		n.ack = 1'b0;
		n.strobe = 1'b0;
		n.rbyte_v = 1'b0;
		gf = 1'b0; adv = 1'b0; emit = 1'b0; fetch = 1'b0; got = 1'b0; last = 1'b0;
		corr = 1'b0; pval = 1'b0; done = 1'b0; ok = 1'b0; bad = 1'b0;
		b = 8'h00; sym = 8'h00; piece = 8'h00; tag = 8'h00; w = 4'h1; mk = 64'h0;
		tx_fetch = 8'h00;
		rx_b = 8'h00;
		tx_byte_ready = 1'b0;

		// Bus: read data captured on the first cycle, write applied on the answer cycle
		if ((avs_read || avs_write) && !s.ack) begin
			n.ack = 1'b1;
			n.rdata = 32'h0000_0000;
			case (avs_address)
				REG_CTRL: n.rdata = {22'h00_0000, s.rxen, s.zseed, 1'b0, s.aack, s.crc,
					s.len, s.mark, s.code64, s.mode};
				REG_SEED: n.rdata = {16'h0000, s.seed};
				REG_TXLEN: n.rdata = {24'h00_0000, s.txlen};
				REG_CHAN: n.rdata = {25'h000_0000, s.chan};
				REG_PINS: n.rdata = {25'h000_0000, s.misooe, s.irqoe, s.misog, s.irqg,
					s.spi3, s.irqm};
				REG_STAT: n.rdata = {26'h000_0000, s.txdone, s.acksent, s.crcerr, s.rxdone,
					s.rst != R_HUNT, s.tst != T_IDLE};
				REG_RXLEN: n.rdata = {24'h00_0000, s.rxlen};
				default: n.rdata = 32'h0000_0000;
			endcase
		end
		if (avs_write && s.ack) begin
			case (avs_address)
				REG_CTRL: begin
					n.mode = avs_writedata[CTL_MODE+:2];
					n.code64 = avs_writedata[CTL_CODE64];
					n.mark = avs_writedata[CTL_MARK];
					n.len = avs_writedata[CTL_LEN];
					n.crc = avs_writedata[CTL_CRC];
					n.aack = avs_writedata[CTL_AACK];
					n.zseed = avs_writedata[CTL_ZSEED];
					n.rxen = avs_writedata[CTL_RXEN];
					if (avs_writedata[CTL_GO]) n.go_pend = 1'b1;
				end
				REG_SEED: n.seed = avs_writedata[15:0];
				REG_TXLEN: n.txlen = avs_writedata[7:0];
				REG_CHAN: if (8'(avs_writedata[6:0]) < CHAN_LIMIT) n.chan = avs_writedata[6:0];
				REG_PINS: begin
					n.irqm = avs_writedata[PIN_IRQ+:2];
					n.spi3 = avs_writedata[PIN_SPI3];
					n.irqg = avs_writedata[PIN_IRQ_OUT];
					n.misog = avs_writedata[PIN_MISO_OUT];
					n.irqoe = avs_writedata[PIN_IRQ_OE];
					n.misooe = avs_writedata[PIN_MISO_OE];
				end
				REG_STAT: begin
					if (avs_writedata[ST_RXDONE]) n.rxdone = 1'b0;
					if (avs_writedata[ST_CRCERR]) n.crcerr = 1'b0;
					if (avs_writedata[ST_ACK]) n.acksent = 1'b0;
					if (avs_writedata[ST_TXDONE]) n.txdone = 1'b0;
				end
				default: ;
			endcase
		end

		// Framing options are snapped only while both directions are quiet
		if (s.tst == T_IDLE && s.left == 4'h0 && !s.have && s.rst == R_HUNT) begin
			n.a_mode = s.mode;
			n.a_code64 = s.code64;
			n.a_mark = s.mark && s.mode != MODE_SINGLE;
			n.a_len = s.len && s.mark && s.mode != MODE_SINGLE;
			if (s.mode == MODE_GFSK || s.mode == MODE_BYTE) begin
				n.a_mark = 1'b1;
				n.a_len = 1'b1;
			end
			n.a_crc = s.crc || s.mode == MODE_GFSK;
		end

		// Transmit pacing: GFSK is self-timed, spread modes follow the modem
		gf = s.a_mode == MODE_GFSK;
		w = wid(s.a_mode);
		if (s.tst != T_IDLE || s.left != 4'h0 || s.have) begin
			n.timer = (s.timer == 8'h00) ? BIT_RELOAD : s.timer - 8'h01;
		end else begin
			n.timer = 8'h00; // Idle pacing stays due, else a stopped timer blocks the next start
		end
		adv = gf ? (s.timer == 8'h00) : (!s.have || tx_sym_ready);

		// Packet start; an acknowledge takes priority over a new packet
		if (s.tst == T_IDLE && s.left == 4'h0 && (s.ack_pend || s.go_pend) && adv) begin
			n.is_ack = s.ack_pend;
			if (s.ack_pend) n.ack_pend = 1'b0;
			else n.go_pend = 1'b0;
			n.bcnt = s.ack_pend ? 8'h00 : s.txlen;
			n.crc_t = s.zseed ? 16'h0000 : s.seed;
			n.mcnt = 1'b0;
			n.tst = n.a_mark ? T_MARK : (n.a_len ? T_LEN : T_PAY); // Fresh snapshot
			n.have = 1'b0; // Any pending symbol was taken on this edge
			n.timer = BIT_RELOAD;
		end else if (adv && s.left != 4'h0) begin
			piece = s.sh;
			emit = 1'b1;
			n.sh = s.sh >> w;
			n.left = s.left - 4'h1;
		end else if (adv && s.tst != T_IDLE) begin
			case (s.tst)
				T_MARK: begin
					if (gf) begin
						b = s.mcnt ? GFSK_MARK[15:8] : GFSK_MARK[7:0];
						fetch = 1'b1;
					end else begin
						tag = s.a_mode == MODE_BYTE ? TAG_BYTE : TAG_DOUBLE;
						mk = s.mcnt ? (MARK_CODE ^ {8{tag}}) : MARK_CODE;
						n.chips = s.a_code64 ? mk : {32'h0000_0000, mk[31:0]};
						n.have = 1'b1;
					end
					n.mcnt = !s.mcnt;
					if (s.mcnt) n.tst = s.a_len ? T_LEN : T_PAY;
				end
				T_LEN: begin
					b = s.bcnt;
					fetch = 1'b1;
					last = s.bcnt == 8'h00;
					n.tst = last ? (s.a_crc ? T_CRC : T_IDLE) : T_PAY;
				end
				T_PAY: begin
					if (s.bcnt == 8'h00) begin
						n.tst = s.a_crc ? T_CRC : T_IDLE;
						n.have = 1'b0;
					end else if (tx_byte_valid && !s.is_ack) begin
						tx_byte_ready = 1'b1;
						b = tx_byte;
						tx_fetch = tx_byte;
						n.crc_t = crc_t_next;
						fetch = 1'b1;
						n.bcnt = s.bcnt - 8'h01;
						if (s.bcnt == 8'h01 && s.a_len) n.tst = s.a_crc ? T_CRC : T_IDLE;
					end else begin
						n.have = 1'b0; // Payload source stalls the frame
					end
				end
				T_CRC: begin
					b = s.mcnt ? s.crc_t[15:8] : s.crc_t[7:0];
					fetch = 1'b1;
					n.mcnt = !s.mcnt;
					if (s.mcnt) n.tst = T_IDLE;
				end
				default: n.tst = T_IDLE;
			endcase
			if (fetch) begin
				piece = b;
				emit = 1'b1;
				n.sh = b >> w;
				n.left = 4'(8 / w - 1);
			end
		end else if (adv) begin
			n.have = 1'b0;
		end
		if (emit) begin
			sym = spread(s.a_mode, piece);
			n.chips = chipify(DATA_CODE, s.a_code64, sym);
			n.bit_v = piece[0];
			n.have = 1'b1;
			n.strobe = gf;
		end
		// Completion reported once the last byte is fetched; its pieces may still be in flight
		if (s.tst != T_IDLE && n.tst == T_IDLE) begin
			if (s.is_ack) n.acksent = 1'b1;
			else n.txdone = 1'b1;
		end

		// Receive: despread and correlate, then assemble bytes LSB first
		if (s.rst == R_HUNT) n.r_mode = s.a_mode;
		if (s.a_mode == MODE_GFSK) begin
			if (rx_bit_valid) begin
				if (s.rst == R_HUNT) begin
					n.rsh = {rx_bit, s.rsh[15:1]};
					if (s.rxen && n.rsh == GFSK_MARK) n.rst = R_LEN;
				end else begin
					piece = {7'h00, rx_bit};
					pval = 1'b1;
				end
			end
		end else if (rx_sym_valid) begin
			sym = rx_chips[7:0] ^ DATA_CODE[7:0];
			corr = rx_chips == chipify(DATA_CODE, s.a_code64, sym);
			corr = corr && sym == spread(s.r_mode, sym);
			mk = s.a_code64 ? MARK_CODE : {32'h0000_0000, MARK_CODE[31:0]};
			tag = rx_chips[7:0] ^ MARK_CODE[7:0];
			case (s.rst)
				R_HUNT: begin
					if (s.rxen && s.a_mark && rx_chips == mk) n.rst = R_MARK2;
					else if (s.rxen && !s.a_mark && corr) begin
						n.rst = R_PAY;
						piece = sym;
						pval = 1'b1;
					end
				end
				R_MARK2: begin
					n.rst = s.a_len ? R_LEN : R_PAY;
					if (rx_chips != (mk ^ chipify(64'h0, s.a_code64, tag))) n.rst = R_HUNT;
					else if (tag == TAG_BYTE) n.r_mode = MODE_BYTE;
					else if (tag == TAG_DOUBLE) n.r_mode = MODE_DOUBLE;
					else n.rst = R_HUNT;
				end
				default: begin
					if (corr) begin
						piece = sym;
						pval = 1'b1;
					end else if (s.a_len) begin
						bad = 1'b1;
					end else begin
						done = 1'b1;
						ok = 1'b1;
					end
				end
			endcase
		end
		if (s.rst == R_HUNT) begin
			n.crc_a = s.seed;
			n.crc_z = 16'h0000;
			n.nbits = 4'h0;
			n.rcb = 1'b0;
		end else if (s.rst == R_MARK2 || n.rst == R_HUNT) begin
			n.nbits = 4'h0;
		end
		if (pval) begin
			w = wid(n.r_mode);
			n.acc = (s.acc >> w) | 8'(piece << (4'h8 - w));
			n.nbits = s.nbits + w;
			got = n.nbits == 4'h8;
			if (got) n.nbits = 4'h0;
		end
		if (got) begin
			rx_b = n.acc;
			case (s.rst)
				R_LEN: begin
					n.rcnt = rx_b;
					n.rxlen = rx_b;
					n.rst = rx_b == 8'h00 ? (s.a_crc ? R_CRC : R_HUNT) : R_PAY;
					if (rx_b == 8'h00 && !s.a_crc) begin
						done = 1'b1;
						ok = 1'b1;
					end
				end
				R_PAY: begin
					n.rbyte = rx_b;
					n.rbyte_v = 1'b1;
					n.crc_a = crc_a_next;
					n.crc_z = crc_z_next;
					if (s.a_len) begin
						n.rcnt = s.rcnt - 8'h01;
						if (s.rcnt == 8'h01) n.rst = s.a_crc ? R_CRC : R_HUNT;
						if (s.rcnt == 8'h01 && !s.a_crc) begin
							done = 1'b1;
							ok = 1'b1;
						end
					end
				end
				R_CRC: begin
					n.rcv = {rx_b, s.rcv[15:8]};
					n.rcb = 1'b1;
					if (s.rcb) begin
						done = 1'b1;
						ok = n.rcv == s.crc_a || n.rcv == s.crc_z;
						bad = !ok;
					end
				end
				default: ;
			endcase
		end
		if (done || bad) n.rst = R_HUNT;
		if (done && ok) begin
			n.rxdone = 1'b1;
			if (s.aack) n.ack_pend = 1'b1;
		end
		if (bad) n.crcerr = 1'b1;
	end

	// State register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.seed <= SEED_RST;
			s.txlen <= TXLEN_RST;
			s.chan <= CHAN_RST;
			s.tst <= T_IDLE;
			s.rst <= R_HUNT;
		end else begin
			s <= n;
		end
	end

	// Interrupt pin polarity or plain output; in the two polarity modes the level follows the sticky flags
	always_comb begin
		logic evt;
		evt = s.rxdone || s.txdone || s.crcerr || s.acksent;
		case (s.irqm)
			IRQ_HIGH: irq_o = evt;
			IRQ_LOW: irq_o = !evt;
			default: irq_o = s.irqg;
		endcase
		irq_oe = (s.irqm == IRQ_GPIO) ? s.irqoe : 1'b1;
	end

	// Serial output: host data in four-wire mode, general I/O in three-wire mode
	assign miso_o = s.spi3 ? s.misog : spi_sdo;
	assign miso_oe = s.spi3 ? s.misooe : spi_sdo_en;

	assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
	assign avs_readdata = s.rdata;
	assign tx_sym_valid = s.have && s.a_mode != MODE_GFSK;
	assign tx_chips = s.chips;
	assign tx_bit = s.bit_v;
	assign tx_bit_strobe = s.strobe;
	assign rx_byte = s.rbyte;
	assign rx_byte_valid = s.rbyte_v;
	assign channel = s.chan;
endmodule // radio_framer

`default_nettype wire

// File: pkg/framer_pkg.sv
// Constants, register map and state types for the baseband mode framer.
// Assumes a 250 MHz system clock and 32-bit Avalon-MM register access.
`default_nettype none

package framer_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SEED = 8'h04;
	localparam logic [7:0] REG_TXLEN = 8'h08;
	localparam logic [7:0] REG_CHAN = 8'h0C;
	localparam logic [7:0] REG_PINS = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam logic [7:0] REG_RXLEN = 8'h18;
	// Control field positions
	localparam int CTL_MODE = 0;
	localparam int CTL_CODE64 = 2;
	localparam int CTL_MARK = 3;
	localparam int CTL_LEN = 4;
	localparam int CTL_CRC = 5;
	localparam int CTL_AACK = 6;
	localparam int CTL_GO = 7;
	localparam int CTL_ZSEED = 8;
	localparam int CTL_RXEN = 9;
	// Pin configuration field positions
	localparam int PIN_IRQ = 0;
	localparam int PIN_SPI3 = 2;
	localparam int PIN_IRQ_OUT = 3;
	localparam int PIN_MISO_OUT = 4;
	localparam int PIN_IRQ_OE = 5;
	localparam int PIN_MISO_OE = 6;
	// Status field positions
	localparam int ST_TXBUSY = 0;
	localparam int ST_RXBUSY = 1;
	localparam int ST_RXDONE = 2;
	localparam int ST_CRCERR = 3;
	localparam int ST_ACK = 4;
	localparam int ST_TXDONE = 5;
	// Reset values
	localparam logic [15:0] SEED_RST = 16'h0000;
	localparam logic [7:0] TXLEN_RST = 8'h00;
	localparam logic [6:0] CHAN_RST = 7'h00;
	// Channel plan
	localparam int CHAN_COUNT = 98;
	localparam int CHAN_SPACING_MHZ = 1;
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int GFSK_RATE_KBPS = 1000;
	localparam int GFSK_BIT_CYCLES = CLK_MHZ * 1000 / GFSK_RATE_KBPS;
	localparam int MARK_SYMBOLS = 2;
	// Codes
	localparam logic [63:0] DATA_CODE = 64'h3C5A_96E1_0F87_B4D2;
	localparam logic [63:0] MARK_CODE = 64'hA6C3_1D5B_E892_47F0;
	localparam logic [15:0] GFSK_MARK = 16'hD391;
	localparam logic [7:0] TAG_BYTE = 8'h00;
	localparam logic [7:0] TAG_DOUBLE = 8'h55;
	localparam logic [15:0] CRC_POLY_REFL = 16'hA001;

	typedef enum logic [1:0] {
		MODE_GFSK = 2'h0,
		MODE_BYTE = 2'h1,
		MODE_DOUBLE = 2'h2,
		MODE_SINGLE = 2'h3
	} mode_t;
	typedef enum logic [1:0] {IRQ_HIGH = 2'h0, IRQ_LOW = 2'h1, IRQ_GPIO = 2'h2} irq_mode_t;
	typedef enum logic [4:0] {
		T_IDLE = 5'h01, T_MARK = 5'h02, T_LEN = 5'h04, T_PAY = 5'h08, T_CRC = 5'h10
	} tx_state_t;
	typedef enum logic [4:0] {
		R_HUNT = 5'h01, R_MARK2 = 5'h02, R_LEN = 5'h04, R_PAY = 5'h08, R_CRC = 5'h10
	} rx_state_t;
endpackage

`default_nettype wire

// File: verilog/crc16_byte.sv
// One-byte update of the reflected 16-bit packet checksum.
// Purely combinational; the caller holds the running value.
`default_nettype none

module crc16_byte
	import framer_pkg::*;
(
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data,
	output logic [15:0] crc_out
);
	// Bits enter LSB first, as they go over the air
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		crc_out = c;
	end
endmodule // crc16_byte

`default_nettype wire

// File: test/radio_framer_props.sv
// Port-level concurrent checks for the radio framer.
// Assumes one mclk domain and an active-low asynchronous arst_n.
`default_nettype none

module radio_framer_props
	import framer_pkg::*;
#(
	parameter int BIT_CYCLES = GFSK_BIT_CYCLES,
	parameter int CHANNELS = CHAN_COUNT
)(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic tx_sym_valid,
	input wire logic tx_sym_ready,
	input wire logic [63:0] tx_chips,
	input wire logic tx_bit_strobe,
	input wire logic rx_sym_valid,
	input wire logic rx_bit_valid,
	input wire logic rx_byte_valid,
	input wire logic [6:0] channel
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [15:0] gap;
	// Cycles since the last bit strobe; saturates so long idle never wraps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gap <= 16'hFFFF;
		end else if (tx_bit_strobe) begin
			gap <= 16'h0000;
		end else if (gap != 16'hFFFF) begin
			gap <= gap + 16'h0001;
		end
	end
	// Bus handshake, then symbol and bit pacing
	a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high while idle");
	a_first_cycle_waits: assert property ((avs_read || avs_write)
		&& !$past(avs_read || avs_write) |-> avs_waitrequest)
		else $error("request answered without a wait cycle");
	a_one_wait_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("more than one wait cycle");
	a_chips_held: assert property (tx_sym_valid && !tx_sym_ready
		|=> tx_sym_valid ##0 $stable(tx_chips))
		else $error("symbol changed before it was taken");
	a_strobe_spacing: assert property (tx_bit_strobe |-> gap >= 16'(BIT_CYCLES - 1))
		else $error("bit strobes closer than one bit time");
	a_strobe_exclusive: assert property (tx_bit_strobe |-> !tx_sym_valid)
		else $error("raw bit and spread symbol together");
	a_rx_after_sym: assert property (rx_byte_valid |-> $past(rx_sym_valid || rx_bit_valid))
		else $error("received byte without a completing symbol");
	a_chan_range: assert property (int'(channel) < CHANNELS)
		else $error("channel outside the plan");
	c_sym_taken: cover property (tx_sym_valid && tx_sym_ready);
	c_bit_sent: cover property (tx_bit_strobe);
	c_rx_byte: cover property (rx_byte_valid);
endmodule // radio_framer_props

bind radio_framer radio_framer_props #(.BIT_CYCLES(BIT_CYCLES), .CHANNELS(CHANNELS)) props (
	.mclk(mclk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .tx_sym_valid(tx_sym_valid),
	.tx_sym_ready(tx_sym_ready), .tx_chips(tx_chips), .tx_bit_strobe(tx_bit_strobe),
	.rx_sym_valid(rx_sym_valid), .rx_bit_valid(rx_bit_valid),
	.rx_byte_valid(rx_byte_valid), .channel(channel)
);

`default_nettype wire

// File: test/remote_radio.sv
// Behavioural far-side radio: takes spread symbols, replays packets back.
// Assumes the framer's symbol handshake on mclk; the raw bit receive path stays idle.
`default_nettype none

module remote_radio
	import framer_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic tx_sym_valid,
	input wire logic [63:0] tx_chips,
	output logic tx_sym_ready,
	output logic rx_sym_valid,
	output logic [63:0] rx_chips,
	output logic rx_bit_valid,
	output logic rx_bit
);
	logic [63:0] cap[$];
	logic [1:0] pace;
	initial begin
		rx_sym_valid = 1'b0;
		rx_chips = 64'h0000_0000_0000_0000;
		rx_bit = 1'b0;
	end
	assign rx_bit_valid = 1'b0;
	// Record each symbol taken; a slow link is ready one cycle in four
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pace <= 2'h0;
			tx_sym_ready <= 1'b0;
		end else begin
			pace <= pace + 2'h1;
			if (tx_sym_valid && tx_sym_ready) begin
				cap.push_back(tx_chips);
			end
			tx_sym_ready <= !slow || (pace == 2'h3);
			rx_bit <= ~rx_bit; // Unused bit line never holds a value
		end
	end
	// Replay symbols as one-cycle pulses; the line shows the inverse between them
	task automatic play(input logic [63:0] pk[$]);
		foreach (pk[i]) begin
			@(posedge mclk);
			rx_chips <= pk[i];
			rx_sym_valid <= 1'b1;
			@(posedge mclk);
			rx_sym_valid <= 1'b0;
			rx_chips <= ~pk[i];
			repeat (2) @(posedge mclk);
		end
	endtask
endmodule // remote_radio

`default_nettype wire

// File: test/radio_framer_test.sv
// Self-checking bench: register access over Avalon-MM, framing in every mode.
// Assumes the remote_radio model and the bound checker; bit time shortened to 4.
`default_nettype none

module radio_framer_test;
	import framer_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] PTAB [6] = '{12'h006, 12'h01E, 12'h2AE, 12'h022, 12'h547, 12'h044};
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rd, st;
	logic avs_waitrequest, tx_byte_ready, tx_sym_valid, tx_sym_ready, tx_bit, tx_bit_strobe;
	logic tx_byte_valid = 1'b0;
	logic rx_sym_valid, rx_bit_valid, rx_bit, rx_byte_valid, irq_o, irq_oe, miso_o, miso_oe;
	logic slow = 1'b0;
	logic [63:0] tx_chips, rx_chips;
	logic [63:0] pkt[$];
	logic [7:0] rx_byte, rx_last;
	logic [15:0] mk;
	logic [6:0] channel;
	logic gq[$];
	int rx_cnt = 0;
	int cycles = 0;
	int checks_done = 0;
	int miscompares = 0;

	radio_framer #(.BIT_CYCLES(4), .CHANNELS(98)) dut (.mclk(mclk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_byte(8'hA5), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_sym_valid(tx_sym_valid),
		.tx_sym_ready(tx_sym_ready), .tx_chips(tx_chips), .tx_bit(tx_bit),
		.tx_bit_strobe(tx_bit_strobe), .rx_sym_valid(rx_sym_valid), .rx_chips(rx_chips),
		.rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid), .channel(channel), .irq_o(irq_o), .irq_oe(irq_oe),
		.spi_sdo(1'b1), .spi_sdo_en(1'b0), .miso_o(miso_o), .miso_oe(miso_oe));
	remote_radio rr (.mclk(mclk), .arst_n(arst_n), .slow(slow), .tx_sym_valid(tx_sym_valid),
		.tx_chips(tx_chips), .tx_sym_ready(tx_sym_ready), .rx_sym_valid(rx_sym_valid),
		.rx_chips(rx_chips), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

	always #2 mclk = ~mclk;
	// Collect received bytes and raw bits; cut a hang short
	always @(posedge mclk) begin
		if (rx_byte_valid === 1'b1) begin
			rx_last <= rx_byte;
			rx_cnt <= rx_cnt + 1;
		end
		if (tx_bit_strobe === 1'b1) begin
			gq.push_back(tx_bit);
		end
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// One bus access; request held until waitrequest is seen low at a rising edge
	task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic poll(input int b);
		st = 32'h0000_0000;
		for (int i = 0; i < 300 && st[b] !== 1'b1; i++) begin
			acc(1'b0, REG_STAT, 32'h0000_0000);
			st = rd;
		end
		chk("status bit", 1, st[b]);
		// Done flags rise at the last byte fetch; let its pieces drain before counting
		repeat (40) @(posedge mclk);
	endtask
	task automatic send(input logic [31:0] c);
		rr.cap.delete();
		gq.delete();
		acc(1'b1, REG_STAT, 32'h0000_003C);
		acc(1'b1, REG_CTRL, c | 32'h0000_0080);
		poll(ST_TXDONE);
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		acc(1'b0, REG_SEED, 32'h0000_0000);
		chk("seed", SEED_RST, rd);
		acc(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", 0, rd);
		acc(1'b1, REG_CHAN, 32'h0000_0061);
		acc(1'b1, REG_CHAN, 32'h0000_0062);
		acc(1'b0, REG_CHAN, 32'h0000_0000);
		chk("channel reg", 97, rd);
		chk("channel pin", 97, channel);
		foreach (PTAB[i]) begin
			acc(1'b1, REG_PINS, {24'h00_0000, PTAB[i][11:4]});
			chk("irq pin", PTAB[i][3:2], {irq_o, irq_oe});
			chk("miso pin", PTAB[i][1:0], {miso_o, miso_oe});
		end
		// Byte mode, 64 chips, full framing, slow far side
		tx_byte_valid <= 1'b1;
		slow <= 1'b1;
		acc(1'b1, REG_TXLEN, 32'h0000_0001);
		send(32'h0000_003D);
		chk("byte symbols", 6, rr.cap.size());
		chk("length symbol", DATA_CODE ^ {8{8'h01}}, rr.cap[2]);
		chk("payload symbol", DATA_CODE ^ {8{8'hA5}}, rr.cap[3]);
		pkt = rr.cap;
		slow <= 1'b0;
		// Receive that byte-mode packet while set for double rate, auto-ack on
		send(32'h0000_0000);
		acc(1'b1, REG_STAT, 32'h0000_003C);
		rr.cap.delete();
		acc(1'b1, REG_CTRL, 32'h0000_027E);
		rr.play(pkt);
		poll(ST_RXDONE);
		chk("rx byte", 8'hA5, rx_last);
		chk("rx count", 1, rx_cnt);
		poll(ST_ACK);
		chk("crc flag", 0, st[ST_CRCERR]);
		chk("ack symbols", 14, rr.cap.size());
		// Corrupted checksum: flagged, never acknowledged
		acc(1'b1, REG_STAT, 32'h0000_003C);
		rr.cap.delete();
		pkt[5] = ~pkt[5];
		rr.play(pkt);
		poll(ST_CRCERR);
		chk("irq event", 1, irq_o);
		acc(1'b0, REG_STAT, 32'h0000_0000);
		chk("no ack", 0, rd[ST_ACK] | rd[ST_RXDONE]);
		chk("no ack symbols", 0, rr.cap.size());
		// Double rate, 32 chips
		send(32'h0000_003A);
		chk("double symbols", 18, rr.cap.size());
		chk("short code", {32'h0000_0000, DATA_CODE[31:0] ^ {4{8'h55}}}, rr.cap[2]);
		// Single rate, 64 chips, unframed
		send(32'h0000_0007);
		chk("single symbols", 8, rr.cap.size());
		chk("single one", ~DATA_CODE, rr.cap[0]);
		chk("single zero", DATA_CODE, rr.cap[1]);
		// Raw bits: marker LSB first, then length, payload, checksum
		send(32'h0000_0000);
		chk("raw bits", 48, gq.size());
		for (int i = 0; i < 16; i++) begin
			mk[i] = gq[i];
		end
		chk("raw marker", GFSK_MARK, mk);
		for (int i = 0; i < 8; i++) begin
			mk[i] = gq[24 + i];
		end
		chk("raw payload", 8'hA5, mk[7:0]);
		summarize();
	end
endmodule // radio_framer_test

`default_nettype wire
